// *** shared/ddr_map_defs.svh ***
`ifndef DDR_MAP_DEFS_SVH
`define DDR_MAP_DEFS_SVH
// system address layout, byte granular, 8 GB span
`define ADDR_W 33
`define COL_LSB 3
`define BANK_LSB 13
`define ROW_LSB 16
`define UNIT_LSB 29
`define NUM_RANKS 4
`define ROW_W_MAX 15
// row widths per device type
`define ROWS_X8_1G 4'hE
`define ROWS_X8_2G 4'hF
`define ROWS_X16_1G 4'hD
`define ROWS_X16_2G 4'hE
`endif

// *** shared/ddr_cfg_pkg.sv ***
package ddr_cfg_pkg;
    typedef enum logic [1:0] {
        CARD_A = 2'b00,
        CARD_B = 2'b01,
        CARD_C = 2'b10,
        CARD_F = 2'b11
    } raw_card_t;
    typedef enum logic {DENS_1G = 1'b0, DENS_2G = 1'b1} density_t;
    typedef enum logic {RATE_800 = 1'b0, RATE_1066 = 1'b1} rate_t;
    typedef struct packed {
        logic [4:0] cl;
        logic [5:0] tras;
        logic [3:0] trcd;
        logic [3:0] trp;
    } timing_t;
    typedef struct packed {
        logic present;
        raw_card_t card;
        density_t density;
        rate_t max_rate;
        timing_t timing;
    } slot_cfg_t;
    typedef struct packed {
        logic [3:0] cs;
        logic [2:0] bank;
        logic [14:0] row;
        logic [9:0] col;
        logic hit;
    } dram_addr_t;
endpackage

// *** verilog/ddr_chan_map.sv ***
// Summary of operation
// (R1) one 64-bit channel takes every cycle
// (R2) two slots, four chip selects at most
// (R3) rate is 800 or 1066 MT/s
// (R4) x8 parts: 14 or 15 row bits
// (R5) x16 parts: 13 or 14 row bits
// (R6) eight banks, three bank bits, ten column bits
// (R7) every rank spans an 8KB page
// (R8) only 1Gb and 2Gb densities decoded
// (R9) module sides match or one is empty
// (R10) each chip select is one rank
// (R11) channel runs at slowest module rate
// (R12) one timing set, worst across modules
// (R13) cards A, B, C, F supported
// (R14) memory down allows card B only
// (R15) unbuffered, no ECC, no register control
// (R16) address splits to rank, bank, row, column
`timescale 1ns/1ns
`include "ddr_map_defs.svh"

module ddr_chan_map (
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_b_i,
    // slot configuration from presence detect
    input ddr_cfg_pkg::slot_cfg_t slot0_i,
    input ddr_cfg_pkg::slot_cfg_t slot1_i,
    input wire logic mem_down_i,
    // request side
    input wire logic req_i,
    input wire logic [`ADDR_W-1:0] addr_i,
    // decoded answer
    output logic ans_valid_o,
    output ddr_cfg_pkg::dram_addr_t ans_o,
    // channel settings
    output ddr_cfg_pkg::rate_t rate_o,
    output ddr_cfg_pkg::timing_t timing_o,
    output logic [3:0] ranks_o,
    output logic cfg_err_o
);
    import ddr_cfg_pkg::*;

    // ****************************************
    // helper functions
    // ****************************************

    // row address width for one device type
    function automatic logic [3:0] row_bits(density_t d, logic x16);
        logic [3:0] w;
        w = `ROWS_X8_1G;
        if (x16) begin
            w = (d == DENS_2G) ? `ROWS_X16_2G : `ROWS_X16_1G; // [R5]
        end else begin
            w = (d == DENS_2G) ? `ROWS_X8_2G : `ROWS_X8_1G; // [R4] [R8]
        end
        return w;
    endfunction

    // rank size in 512 MB units; page is always 8KB
    function automatic logic [4:0] rank_units(logic [3:0] rw);
        logic [4:0] u;
        u = 5'h01 << (rw - `ROWS_X16_1G); // [R7]
        return u;
    endfunction

    // card traits: x16 parts and two chip selects
    function automatic logic card_x16(raw_card_t c);
        return (c == CARD_A) || (c == CARD_C); // [R13]
    endfunction

    function automatic logic card_dual(raw_card_t c);
        return (c == CARD_A) || (c == CARD_F); // [R13] [R10]
    endfunction

    // ****************************************
    // rank table
    // ****************************************

    slot_cfg_t slot [2];
    logic [3:0] rank_en;
    logic [3:0] rw [4];
    logic [4:0] units [4];
    logic [4:0] base [4];

    assign slot[0] = slot0_i;
    assign slot[1] = slot1_i;

    // one chip select per rank, two per slot
    always_comb begin
        for (int r = 0; r < `NUM_RANKS; r++) begin
            rank_en[r] = slot[r/2].present
                && ((r % 2 == 0) || card_dual(slot[r/2].card)); // [R2] [R10]
            rw[r] = row_bits(slot[r/2].density, card_x16(slot[r/2].card));
            units[r] = rank_en[r] ? rank_units(rw[r]) : 5'h00;
        end
    end

    // ranks stacked back to back from address zero
    always_comb begin
        base[0] = 5'h00;
        for (int r = 1; r < `NUM_RANKS; r++) begin
            base[r] = base[r-1] + units[r-1];
        end
    end

    // ****************************************
    // address decode
    // ****************************************

    dram_addr_t next_ans;
    logic [4:0] unit;
    logic [16:0] offs;
    logic [14:0] mask;

    assign unit = {1'b0, addr_i[`ADDR_W-1:`UNIT_LSB]};

    // single channel: every request decodes here
    always_comb begin
        next_ans = '0; // [R1]
        offs = '0;
        mask = '0;
        next_ans.bank = addr_i[`BANK_LSB +: 3]; // [R6]
        next_ans.col = addr_i[`COL_LSB +: 10]; // [R6]
        for (int r = 0; r < `NUM_RANKS; r++) begin
            if (rank_en[r] && unit >= base[r]
                && unit < base[r] + units[r]) begin
                // one 512 MB unit spans 13 row address bits
                offs = addr_i[`ADDR_W-1:`ROW_LSB] - {base[r][3:0], 13'h0000};
                mask = 15'h7FFF >> (4'hF - rw[r]);
                next_ans.cs = 4'h1 << r; // [R10] [R16]
                next_ans.row = offs[14:0] & mask; // [R4] [R5] [R16]
                next_ans.hit = 1'b1;
            end
        end
    end

    // answer registered one cycle after the request
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            ans_valid_o <= 1'b0;
            ans_o <= '0;
        end else begin
            ans_valid_o <= req_i; // [R1]
            if (req_i) begin
                ans_o <= next_ans; // [R16]
            end
        end
    end

    // ****************************************
    // channel settings
    // ****************************************

    rate_t next_rate;
    timing_t next_tim;
    logic next_err;

    // slowest module and worst timing win
    always_comb begin
        next_rate = RATE_1066;
        next_tim = '0;
        for (int s = 0; s < 2; s++) begin
            if (slot[s].present) begin
                if (slot[s].max_rate == RATE_800) begin
                    next_rate = RATE_800; // [R3] [R11]
                end
                if (slot[s].timing.cl > next_tim.cl) begin
                    next_tim.cl = slot[s].timing.cl; // [R12]
                end
                if (slot[s].timing.tras > next_tim.tras) begin
                    next_tim.tras = slot[s].timing.tras; // [R12]
                end
                if (slot[s].timing.trcd > next_tim.trcd) begin
                    next_tim.trcd = slot[s].timing.trcd; // [R12]
                end
                if (slot[s].timing.trp > next_tim.trp) begin
                    next_tim.trp = slot[s].timing.trp; // [R12]
                end
            end
        end
    end

    // soldered parts: one card B topology in slot 0 only
    assign next_err = mem_down_i
        && ((slot0_i.present && slot0_i.card != CARD_B)
        || slot1_i.present); // [R14]

    // settings refresh every cycle; no ECC or buffer control exists
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rate_o <= RATE_800;
            timing_o <= '0;
            ranks_o <= 4'h0;
            cfg_err_o <= 1'b0;
        end else begin
            rate_o <= next_rate; // [R3] [R15]
            timing_o <= next_tim; // [R12]
            ranks_o <= rank_en; // [R2]
            cfg_err_o <= next_err; // [R14]
        end
    end

    // ****************************************
    // assertions
    // ****************************************

    property p_answer_follows;
        @(posedge clk_i) disable iff (!rst_b_i)
        req_i |=> ans_valid_o;
    endproperty
    a_answer_follows: assert property (p_answer_follows) // [R1]
        else $error("answer missing after request");

    property p_cs_onehot;
        @(posedge clk_i) disable iff (!rst_b_i)
        ans_valid_o |-> ($onehot(ans_o.cs) == ans_o.hit);
    endproperty
    a_cs_onehot: assert property (p_cs_onehot) // [R10]
        else $error("chip select not one-hot on hit");

    property p_cs_present;
        @(posedge clk_i) disable iff (!rst_b_i)
        req_i ##1 ($stable(slot0_i) && $stable(slot1_i))
            |-> (ans_o.cs & ~ranks_o) == 4'h0;
    endproperty
    a_cs_present: assert property (p_cs_present) // [R2]
        else $error("absent rank selected");

    property p_rate_slowest;
        @(posedge clk_i) disable iff (!rst_b_i)
        (slot0_i.present && slot0_i.max_rate == RATE_800)
            |=> rate_o == RATE_800;
    endproperty
    a_rate_slowest: assert property (p_rate_slowest) // [R11]
        else $error("rate above slowest module");

    property p_rate_fast;
        @(posedge clk_i) disable iff (!rst_b_i)
        (!slot0_i.present || slot0_i.max_rate == RATE_1066)
            && (!slot1_i.present || slot1_i.max_rate == RATE_1066)
            |=> rate_o == RATE_1066;
    endproperty
    a_rate_fast: assert property (p_rate_fast) // [R3]
        else $error("rate not raised to 1066");

    property p_x16_1g_rows;
        @(posedge clk_i) disable iff (!rst_b_i)
        req_i && $stable(slot0_i) && next_ans.cs[0]
            && card_x16(slot0_i.card) && slot0_i.density == DENS_1G
            |=> ans_o.row[14:13] == 2'b00;
    endproperty
    a_x16_1g_rows: assert property (p_x16_1g_rows) // [R5]
        else $error("x16 1Gb row wider than 13 bits");

    property p_x8_1g_rows;
        @(posedge clk_i) disable iff (!rst_b_i)
        req_i && next_ans.cs[0] && !card_x16(slot0_i.card)
            && slot0_i.density == DENS_1G
            |=> ans_o.row[14] == 1'b0;
    endproperty
    a_x8_1g_rows: assert property (p_x8_1g_rows) // [R4] [R8]
        else $error("x8 1Gb row wider than 14 bits");

    property p_bank_col;
        @(posedge clk_i) disable iff (!rst_b_i)
        req_i |=> ans_o.col == $past(addr_i[12:3])
            && ans_o.bank == $past(addr_i[15:13]);
    endproperty
    a_bank_col: assert property (p_bank_col) // [R6] [R7]
        else $error("bank or column field wrong");

    property p_timing_worst;
        @(posedge clk_i) disable iff (!rst_b_i)
        slot1_i.present |=> timing_o.cl >= $past(slot1_i.timing.cl)
            && timing_o.trp >= $past(slot1_i.timing.trp);
    endproperty
    a_timing_worst: assert property (p_timing_worst) // [R12]
        else $error("timing below module need");

    property p_mem_down;
        @(posedge clk_i) disable iff (!rst_b_i)
        mem_down_i && slot0_i.present && slot0_i.card != CARD_B
            |=> cfg_err_o;
    endproperty
    a_mem_down: assert property (p_mem_down) // [R14]
        else $error("memory down card not flagged");

    property p_rank_zero;
        @(posedge clk_i) disable iff (!rst_b_i)
        req_i && slot0_i.present && addr_i[`ADDR_W-1:`UNIT_LSB] == 4'h0
            |=> ans_o.hit && ans_o.cs == 4'h1;
    endproperty
    a_rank_zero: assert property (p_rank_zero) // [R16]
        else $error("low address not on rank 0");

    c_rank3: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        ans_valid_o && ans_o.cs[3]);
    c_miss: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        ans_valid_o && !ans_o.hit);
    c_fast: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        rate_o == RATE_1066 && ranks_o == 4'hF);
    c_err: cover property (@(posedge clk_i) disable iff (!rst_b_i)
        cfg_err_o);

endmodule // ddr_chan_map

// *** test/dimm_spd_model.sv ***
`timescale 1ns/1ns
module dimm_spd_model (
    // slot population
    input wire logic fit0_i,
    input wire logic fit1_i,
    // module profile per slot
    input wire logic [1:0] kind0_i,
    input wire logic [1:0] kind1_i,
    // presence detect contents
    output ddr_cfg_pkg::slot_cfg_t slot0_o,
    output ddr_cfg_pkg::slot_cfg_t slot1_o
);
    import ddr_cfg_pkg::*;
    // one technology per module, both sides alike
    function automatic slot_cfg_t profile(input logic fit, input logic [1:0] kind);
        slot_cfg_t p;
        case (kind)
            2'h0: p = '{1'h1, CARD_A, DENS_1G, RATE_1066, '{5'h07, 6'h14, 4'h7, 4'h7}};
            2'h1: p = '{1'h1, CARD_B, DENS_1G, RATE_800, '{5'h06, 6'h0F, 4'h6, 4'h6}};
            2'h2: p = '{1'h1, CARD_C, DENS_2G, RATE_1066, '{5'h08, 6'h12, 4'h5, 4'h8}};
            default: p = '{1'h1, CARD_F, DENS_2G, RATE_1066, '{5'h07, 6'h18, 4'h7, 4'h7}};
        endcase
        // empty slot reads as junk
        if (!fit) p = '{1'h0, CARD_F, DENS_2G, RATE_800, '{5'h1F, 6'h3F, 4'hF, 4'hF}};
        return p;
    endfunction
    assign slot0_o = profile(fit0_i, kind0_i);
    assign slot1_o = profile(fit1_i, kind1_i);
endmodule // dimm_spd_model

// *** test/ddr_chan_map_tb.sv ***
`timescale 1ns/1ns
module ddr_chan_map_tb;
    import ddr_cfg_pkg::*;
    typedef struct packed {
        logic [5:0] sel;
        logic md;
        rate_t rate;
        logic [3:0] ranks;
        timing_t tim;
        logic err;
    } row_t;
    // fit0 fit1 kind0 kind1, memory down, expected settings
    row_t rows[9] = '{
        '{6'h20, 1'h0, RATE_1066, 4'h3, '{5'h07, 6'h14, 4'h7, 4'h7}, 1'h0},
        '{6'h24, 1'h0, RATE_800, 4'h1, '{5'h06, 6'h0F, 4'h6, 4'h6}, 1'h0},
        '{6'h3B, 1'h0, RATE_1066, 4'hD, '{5'h08, 6'h18, 4'h7, 4'h8}, 1'h0},
        '{6'h3D, 1'h0, RATE_800, 4'h7, '{5'h07, 6'h18, 4'h7, 4'h7}, 1'h0},
        '{6'h12, 1'h0, RATE_1066, 4'h4, '{5'h08, 6'h12, 4'h5, 4'h8}, 1'h0},
        '{6'h24, 1'h1, RATE_800, 4'h1, '{5'h06, 6'h0F, 4'h6, 4'h6}, 1'h0},
        '{6'h20, 1'h1, RATE_1066, 4'h3, '{5'h07, 6'h14, 4'h7, 4'h7}, 1'h1},
        '{6'h36, 1'h1, RATE_800, 4'h5, '{5'h08, 6'h12, 4'h6, 4'h8}, 1'h1},
        '{6'h00, 1'h0, RATE_1066, 4'h0, '{5'h00, 6'h00, 4'h0, 4'h0}, 1'h0}};
    logic clk_i, rst_b_i, req_i, mem_down, ans_valid_o, cfg_err_o;
    logic [5:0] sel;
    logic [32:0] addr_i;
    slot_cfg_t slot0, slot1;
    dram_addr_t ans_o;
    rate_t rate_o;
    timing_t timing_o;
    logic [3:0] ranks_o;
    int mismatches = 0;
    int tests_run = 0;
    int cycles = 0;
    dimm_spd_model far_side (.fit0_i(sel[5]), .fit1_i(sel[4]), .kind0_i(sel[3:2]),
        .kind1_i(sel[1:0]), .slot0_o(slot0), .slot1_o(slot1));
    ddr_chan_map DUT (.clk_i(clk_i), .rst_b_i(rst_b_i), .slot0_i(slot0), .slot1_i(slot1),
        .mem_down_i(mem_down), .req_i(req_i), .addr_i(addr_i), .ans_valid_o(ans_valid_o),
        .ans_o(ans_o), .rate_o(rate_o), .timing_o(timing_o), .ranks_o(ranks_o),
        .cfg_err_o(cfg_err_o));
    // ****************
    // clock and helpers
    // ****************
    initial begin
        clk_i = 1'h0;
        forever #50 clk_i = ~clk_i;
    end
    task automatic tick;
        @(posedge clk_i);
        #1;
    endtask
    task automatic check(input logic [39:0] seen, input logic [39:0] exp, input string what);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t ns %s: saw %h want %h", $time, what, seen, exp);
        end
    endtask
    // answer strobe and decoded fields
    task automatic expect_ans(input logic v, input logic [3:0] cs, input logic [2:0] bank,
        input logic [14:0] row, input logic [9:0] col, input logic hit);
        dram_addr_t e;
        e = '{cs, bank, row, col, hit};
        check(ans_valid_o, v, "strobe");
        check(ans_o, e, "decode");
    endtask
    task print_verdict;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // hang guard
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            $display("[FAIL] %0t ns timeout", $time);
            print_verdict;
        end
    end
    // ****************
    // main sequence
    // ****************
    initial begin
        rst_b_i = 1'h0;
        req_i = 1'h0;
        addr_i = 33'h0;
        sel = 6'h0;
        mem_down = 1'h0;
        repeat (6) @(posedge clk_i);
        #1;
        check(rate_o, RATE_800, "reset rate");
        check(ranks_o, 4'h0, "reset ranks");
        rst_b_i = 1'h1;
        $display("test reset done");
        foreach (rows[i]) begin
            sel = rows[i].sel;
            mem_down = rows[i].md;
            tick;
            check(rate_o, rows[i].rate, "rate");
            check(timing_o, rows[i].tim, "timing");
            check(ranks_o, rows[i].ranks, "ranks");
            check(cfg_err_o, rows[i].err, "config");
        end
        $display("test settings table done");
        // two ranks of 2Gb x8, back to back, then past the top
        sel = 6'h2C;
        tick;
        req_i = 1'h1;
        addr_i = 33'h0_7FFF_FFF8;
        tick;
        addr_i = 33'h0_8001_2340;
        expect_ans(1'h1, 4'h1, 3'h7, 15'h7FFF, 10'h3FF, 1'h1);
        tick;
        addr_i = 33'h1_0000_A008;
        expect_ans(1'h1, 4'h2, 3'h1, 15'h0001, 10'h068, 1'h1);
        tick;
        req_i = 1'h0;
        expect_ans(1'h1, 4'h0, 3'h5, 15'h0000, 10'h001, 1'h0);
        tick;
        expect_ans(1'h0, 4'h0, 3'h5, 15'h0000, 10'h001, 1'h0);
        $display("test x8 decode done");
        // one rank of 1Gb x8: top row, then the first miss
        sel = 6'h24;
        tick;
        req_i = 1'h1;
        addr_i = 33'h0_3FFF_FFF8;
        tick;
        addr_i = 33'h0_4000_0000;
        expect_ans(1'h1, 4'h1, 3'h7, 15'h3FFF, 10'h3FF, 1'h1);
        tick;
        req_i = 1'h0;
        expect_ans(1'h1, 4'h0, 3'h0, 15'h0000, 10'h000, 1'h0);
        $display("test x8 1Gb decode done");
        // 1Gb x16 two ranks in slot0, 1Gb x8 in slot1
        sel = 6'h31;
        tick;
        req_i = 1'h1;
        addr_i = 33'h0_1234_5678;
        tick;
        addr_i = 33'h0_3FFF_0000;
        expect_ans(1'h1, 4'h1, 3'h2, 15'h1234, 10'h2CF, 1'h1);
        tick;
        addr_i = 33'h0_4000_0000;
        expect_ans(1'h1, 4'h2, 3'h0, 15'h1FFF, 10'h000, 1'h1);
        tick;
        expect_ans(1'h1, 4'h4, 3'h0, 15'h0000, 10'h000, 1'h1);
        rst_b_i = 1'h0;
        req_i = 1'h0;
        #1;
        check(ans_valid_o, 1'h0, "mid reset strobe");
        check(ranks_o, 4'h0, "mid reset ranks");
        tick;
        rst_b_i = 1'h1;
        tick;
        check(ranks_o, 4'h7, "ranks after reset");
        check(ans_valid_o, 1'h0, "strobe after reset");
        $display("test x16 decode and reset done");
        print_verdict;
    end
endmodule // ddr_chan_map_tb
